// File: acrg_host_model.sv
// host register master model driving the block's access strobes
`timescale 1ns/100ps
`include "acrg_params.svh"
module acrg_host_model (
    // clock
    input wire logic clk_i,
    // register access
    output acrg_pkg::acrg_host_type host_o,
    input wire logic [`ACRG_RDATA_W-1:0] rdata_i
);
    initial begin
        host_o = '0;
    end
    // strobes change only at the falling edge, away from the sampling edge
    task automatic wr(input logic [`ACRG_ADDR_W-1:0] a, input logic [`ACRG_CFG_W-1:0] dat);
        @(negedge clk_i);
        host_o.addr = a;
        host_o.wdata = dat;
        host_o.wr = 1'h1;
        @(negedge clk_i);
        host_o.wr = 1'h0;
    endtask
    // address stays put while busy, or a result load could slip in
    task automatic rd(input logic [`ACRG_ADDR_W-1:0] a, input int busy,
                      output logic [`ACRG_RDATA_W-1:0] dat);
        @(negedge clk_i);
        host_o.addr = a;
        host_o.rd_start = 1'h1;
        host_o.rd_busy = 1'h1;
        @(negedge clk_i);
        host_o.rd_start = 1'h0;
        dat = rdata_i;
        repeat (busy) @(negedge clk_i);
        host_o.rd_busy = 1'h0;
    endtask
endmodule // acrg_host_model

// File: acrg_params.svh
// offsets, field positions, reset values and codes of the check/result/pin register group
`ifndef ACRG_PARAMS_SVH
`define ACRG_PARAMS_SVH

`define ACRG_ADDR_W 6
`define ACRG_OFF_CHECKSUM 6'h03
`define ACRG_OFF_RESULT 6'h04
`define ACRG_OFF_PINCFG 6'h06

`define ACRG_RESULT_W 24
`define ACRG_SHORT_W 16
`define ACRG_RDATA_W 32
`define ACRG_CFG_W 16
`define ACRG_STATUS_W 8

`define ACRG_CFG_RESET 16'h0800
`define ACRG_CFG_WRITE_MASK 16'h1f3f
`define ACRG_CFG_MUX_BIT 12
`define ACRG_CFG_SYNC_BIT 11
`define ACRG_CFG_ERRMODE_HI 10
`define ACRG_CFG_ERRMODE_LO 9
`define ACRG_CFG_PINLVL_BIT 8
`define ACRG_CFG_IPEN_LO 4
`define ACRG_CFG_OPEN_LO 2
`define ACRG_CFG_GPDATA_LO 0

`define ACRG_ERRMODE_OFF 2'h0
`define ACRG_ERRMODE_IN 2'h1
`define ACRG_ERRMODE_OD 2'h2
`define ACRG_ERRMODE_GPO 2'h3

`define ACRG_STAT_RDY_BIT 7
`define ACRG_STAT_ADCERR_BIT 6
`define ACRG_STAT_CRCERR_BIT 5
`define ACRG_STAT_REGERR_BIT 4

`define ACRG_ROUND_HALF 25'h0000080
`define ACRG_SHORT_MAX 16'hffff
`define ACRG_ZERO_RESULT 24'h000000
`define ACRG_ZERO_RDATA 32'h00000000

`endif

// File: acrg_pkg.sv
// types shared by the check/result/pin register group
`include "acrg_params.svh"
package acrg_pkg;

    typedef struct packed {
        logic [`ACRG_ADDR_W-1:0] addr;
        logic wr;
        logic [`ACRG_CFG_W-1:0] wdata;
        logic rd_start;
        logic rd_busy;
    } acrg_host_type;

    typedef struct packed {
        logic check_enable;
        logic status_append;
        logic short_word_select;
        logic alternate_sync_mode;
        logic bipolar_select;
        logic multi_channel;
    } acrg_mode_type;

    typedef struct packed {
        logic conv_done;
        logic [`ACRG_RESULT_W-1:0] raw;
        logic [1:0] channel;
        logic channel_switch;
        logic adc_error;
        logic crc_error;
        logic [`ACRG_STATUS_W-1:0] status_low;
        logic [`ACRG_RESULT_W-1:0] checked_xor;
    } acrg_conv_type;

    typedef struct packed {
        logic [`ACRG_CFG_W-1:0] cfg;
        logic [`ACRG_RESULT_W-1:0] result;
        logic rdy_n;
        logic reg_error;
        logic check_armed;
        logic [`ACRG_RESULT_W-1:0] check_ref;
        logic conv_error;
        logic conv_hold;
        logic mod_reset;
        logic [`ACRG_RDATA_W-1:0] rdata;
        logic [1:0] gp_o;
        logic [1:0] gp_oe;
        logic sync_o;
        logic sync_oe;
    } acrg_state_type;

endpackage

// File: acrg_regs.sv
// checksum, conversion result and pin configuration registers of the converter
`timescale 1ns/100ps
`include "acrg_params.svh"
//
// Behaviour
// - read-only 24-bit checksum at 0x03 is XOR of configuration registers
// - checksum reads zero unless integrity checking is enabled
// - result at 0x04 is offset binary, or straight binary when unipolar
// - reading the result forces ready bit and ready pin high
// - result may be reread unchanged; ready stays high after first read
// - no new result is loaded while the result is being read
// - with status append, result read carries status byte, 32 bits total
// - with short word selected, result is rounded to 16 bits
// - pin config resets to 0x0800; bits 15:13 read zero
// - external mux control drives both general pins with sequencer channel
// - external mux sequencing covers at most four channels at once
// - sync input enabled: low pin holds modulator and filter in reset
// - alternate sync with multiple channels: low pin does not reset
// - alternate sync: low pin at channel switch blocks next conversion
// - error input mode: inverted pin joins converter error, pin in level bit
// - error output mode: open-drain pin carries inverted OR of error bits
// - mode 00 disables; general output drives pin to the level bit
// - any checked register change while checking sets register error
// - level bit drives pin as output, returns pin level as input
module acrg_regs #(
    parameter int unsigned MUX_CHANNELS = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // host register access
    input wire acrg_pkg::acrg_host_type host_i,
    output logic [`ACRG_RDATA_W-1:0] rdata_o,
    // interface mode bits and converter core
    input wire acrg_pkg::acrg_mode_type mode_i,
    input wire acrg_pkg::acrg_conv_type conv_i,
    // status and control towards the core
    output logic ready_pin_o,
    output logic ready_bit_o,
    output logic register_error_o,
    output logic converter_error_o,
    output logic modulator_reset_o,
    output logic conversion_hold_o,
    output logic [`ACRG_CFG_W-1:0] io_pin_config_o,
    // sync/error pin
    input wire logic sync_error_pin_i,
    output logic sync_error_pin_o,
    output logic sync_error_pin_oe_o,
    // general pins, bit 0 is general_pin_zero, bit 1 general_pin_one
    input wire logic [1:0] general_pin_i,
    output logic [1:0] general_pin_o,
    output logic [1:0] general_pin_oe_o
);

    // two select pins give four mux positions; more cannot be encoded
    if (MUX_CHANNELS != 4) begin : g_bad_mux
        $error("acrg_regs: MUX_CHANNELS must be 4");
    end

    acrg_pkg::acrg_state_type q;
    acrg_pkg::acrg_state_type next_q;

    logic [1:0] err_mode;
    logic alt_active;
    logic reading_result;
    logic [`ACRG_RESULT_W-1:0] checksum;
    logic [`ACRG_RESULT_W-1:0] coded;
    logic [`ACRG_RESULT_W:0] rounded;
    logic [`ACRG_RESULT_W-1:0] formatted;
    logic [`ACRG_STATUS_W-1:0] status_byte;
    logic [`ACRG_CFG_W-1:0] cfg_view;
    logic any_error;

    always_comb begin
        next_q = q;
        err_mode = q.cfg[`ACRG_CFG_ERRMODE_HI:`ACRG_CFG_ERRMODE_LO];
        alt_active = mode_i.alternate_sync_mode && mode_i.multi_channel;
        reading_result = (host_i.rd_start || host_i.rd_busy)
            && (host_i.addr == `ACRG_OFF_RESULT);
        checksum = conv_i.checked_xor ^ {8'h00, q.cfg};

        // result coding and optional rounding
        coded = mode_i.bipolar_select
            ? {~conv_i.raw[`ACRG_RESULT_W-1], conv_i.raw[`ACRG_RESULT_W-2:0]}
            : conv_i.raw;
        rounded = {1'b0, coded} + `ACRG_ROUND_HALF;
        if (!mode_i.short_word_select) begin
            formatted = coded;
        end else if (rounded[`ACRG_RESULT_W]) begin
            formatted = {8'h00, `ACRG_SHORT_MAX};
        end else begin
            formatted = {8'h00, rounded[`ACRG_RESULT_W-1:8]};
        end

        // a read in progress freezes the result; that conversion is dropped
        if (conv_i.conv_done && !reading_result) begin
            next_q.result = formatted;
            next_q.rdy_n = 1'b0;
        end
        if (host_i.rd_start && host_i.addr == `ACRG_OFF_RESULT) begin
            next_q.rdy_n = 1'b1;
        end

        // register writes; reserved bits never stored
        if (host_i.wr && host_i.addr == `ACRG_OFF_PINCFG) begin
            next_q.cfg = host_i.wdata & `ACRG_CFG_WRITE_MASK;
        end

        // integrity check: reference taken when checking turns on
        if (!mode_i.check_enable) begin
            next_q.check_armed = 1'b0;
            next_q.reg_error = 1'b0;
        end else if (!q.check_armed) begin
            next_q.check_armed = 1'b1;
            next_q.check_ref = checksum;
        end else if (checksum != q.check_ref) begin
            next_q.reg_error = 1'b1;
        end

        // converter error: pin error input joins core error
        next_q.conv_error = conv_i.adc_error
            || (err_mode == `ACRG_ERRMODE_IN && !sync_error_pin_i);

        // sync handling
        next_q.mod_reset = q.cfg[`ACRG_CFG_SYNC_BIT] && !alt_active
            && !sync_error_pin_i;
        if (!(q.cfg[`ACRG_CFG_SYNC_BIT] && alt_active) || sync_error_pin_i) begin
            next_q.conv_hold = 1'b0;
        end else if (conv_i.channel_switch) begin
            next_q.conv_hold = 1'b1;
        end

        // status byte and error pin drive
        status_byte = conv_i.status_low;
        status_byte[`ACRG_STAT_RDY_BIT] = q.rdy_n;
        status_byte[`ACRG_STAT_ADCERR_BIT] = q.conv_error;
        status_byte[`ACRG_STAT_CRCERR_BIT] = conv_i.crc_error;
        status_byte[`ACRG_STAT_REGERR_BIT] = q.reg_error;
        any_error = q.conv_error || conv_i.crc_error || q.reg_error;
        case (err_mode)
            `ACRG_ERRMODE_OD: begin
                next_q.sync_o = 1'b0;
                next_q.sync_oe = any_error;
            end
            `ACRG_ERRMODE_GPO: begin
                next_q.sync_o = q.cfg[`ACRG_CFG_PINLVL_BIT];
                next_q.sync_oe = 1'b1;
            end
            default: begin
                next_q.sync_o = 1'b0;
                next_q.sync_oe = 1'b0;
            end
        endcase

        // general pins: mux select code or plain I/O
        for (int i = 0; i < 2; i++) begin
            if (q.cfg[`ACRG_CFG_MUX_BIT]) begin
                next_q.gp_o[i] = conv_i.channel[i];
                next_q.gp_oe[i] = 1'b1;
            end else begin
                next_q.gp_o[i] = q.cfg[`ACRG_CFG_GPDATA_LO + i];
                next_q.gp_oe[i] = q.cfg[`ACRG_CFG_OPEN_LO + i];
            end
        end

        // readback view of the pin config with live input levels
        cfg_view = q.cfg;
        if (err_mode == `ACRG_ERRMODE_IN) begin
            cfg_view[`ACRG_CFG_PINLVL_BIT] = sync_error_pin_i;
        end
        for (int i = 0; i < 2; i++) begin
            if (q.cfg[`ACRG_CFG_IPEN_LO + i]) begin
                cfg_view[`ACRG_CFG_GPDATA_LO + i] = general_pin_i[i];
            end
        end

        // read data captured at read start, held until the next read
        if (host_i.rd_start) begin
            case (host_i.addr)
                `ACRG_OFF_CHECKSUM: begin
                    next_q.rdata = mode_i.check_enable
                        ? {8'h00, checksum} : `ACRG_ZERO_RDATA;
                end
                `ACRG_OFF_RESULT: begin
                    next_q.rdata = mode_i.status_append
                        ? {q.result, status_byte}
                        : {8'h00, q.result};
                end
                `ACRG_OFF_PINCFG: begin
                    next_q.rdata = {16'h0000, cfg_view};
                end
                default: begin
                    next_q.rdata = `ACRG_ZERO_RDATA;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.cfg <= `ACRG_CFG_RESET;
            q.rdy_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;
    assign ready_pin_o = q.rdy_n;
    assign ready_bit_o = q.rdy_n;
    assign register_error_o = q.reg_error;
    assign converter_error_o = q.conv_error;
    assign modulator_reset_o = q.mod_reset;
    assign conversion_hold_o = q.conv_hold;
    assign io_pin_config_o = q.cfg;
    assign sync_error_pin_o = q.sync_o;
    assign sync_error_pin_oe_o = q.sync_oe;
    assign general_pin_o = q.gp_o;
    assign general_pin_oe_o = q.gp_oe;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_check_zero;
        host_i.rd_start && host_i.addr == `ACRG_OFF_CHECKSUM && !mode_i.check_enable
            |=> rdata_o == `ACRG_ZERO_RDATA;
    endproperty
    a_check_zero: assert property (p_check_zero) else $error("checksum not zero");

    property p_read_ready;
        host_i.rd_start && host_i.addr == `ACRG_OFF_RESULT |=> ready_pin_o && ready_bit_o;
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("ready not high");

    property p_read_freeze;
        host_i.rd_busy && host_i.addr == `ACRG_OFF_RESULT |=> $stable(q.result);
    endproperty
    a_read_freeze: assert property (p_read_freeze) else $error("result changed");

    property p_conv_load;
        conv_i.conv_done && !host_i.rd_start && !host_i.rd_busy
            |=> !ready_pin_o
            ##1 (ready_pin_o || !$past(host_i.rd_start && host_i.addr == `ACRG_OFF_RESULT));
    endproperty
    a_conv_load: assert property (p_conv_load) else $error("ready not low");

    property p_reserved;
        io_pin_config_o[15:13] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved set");

    property p_mux_pins;
        io_pin_config_o[`ACRG_CFG_MUX_BIT]
            |=> general_pin_oe_o == 2'h3 && general_pin_o == $past(conv_i.channel);
    endproperty
    a_mux_pins: assert property (p_mux_pins) else $error("mux code wrong");

    property p_sync_reset;
        io_pin_config_o[`ACRG_CFG_SYNC_BIT] && !mode_i.alternate_sync_mode
            && !sync_error_pin_i |=> modulator_reset_o;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("no sync reset");

    property p_alt_noreset;
        mode_i.alternate_sync_mode && mode_i.multi_channel |=> !modulator_reset_o;
    endproperty
    a_alt_noreset: assert property (p_alt_noreset) else $error("alt reset");

    property p_alt_hold;
        io_pin_config_o[`ACRG_CFG_SYNC_BIT] && alt_active && conv_i.channel_switch
            && !sync_error_pin_i |=> conversion_hold_o;
    endproperty
    a_alt_hold: assert property (p_alt_hold) else $error("no hold");

    property p_err_od;
        err_mode == `ACRG_ERRMODE_OD
            |=> !sync_error_pin_o && sync_error_pin_oe_o == $past(any_error);
    endproperty
    a_err_od: assert property (p_err_od) else $error("error pin wrong");

    property p_regerr;
        mode_i.check_enable && q.check_armed && checksum != q.check_ref
            |=> register_error_o ##1 (register_error_o || !$past(mode_i.check_enable));
    endproperty
    a_regerr: assert property (p_regerr) else $error("no register error");

endmodule // acrg_regs

// File: testbench.sv
// self-checking bench for the check/result/pin register group
`timescale 1ns/100ps
`include "acrg_params.svh"
module testbench;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    acrg_pkg::acrg_host_type host;
    acrg_pkg::acrg_mode_type mode = '0;
    acrg_pkg::acrg_conv_type conv = '0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic rdy_pin, rdy_bit, reg_err, conv_err, mod_rst, hold;
    logic [15:0] cfg;
    logic sync_o, sync_oe;
    logic tb_sync = 1'h1;
    logic [1:0] gp_o, gp_oe;
    logic [1:0] tb_gp = 2'h1;
    // released sync pin sits at the pull-up unless the bench pulls it
    wire sync_pin = sync_oe ? sync_o : tb_sync;
    wire [1:0] gp_pin = (gp_oe & gp_o) | (~gp_oe & tb_gp);
    int fails = 0;
    int checked = 0;
    int cycles = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    acrg_host_model acrg_host_model_i (.clk_i(clk), .host_o(host), .rdata_i(rdata));

    acrg_regs #(.MUX_CHANNELS(4)) acrg_regs_i (
        .clk_i(clk), .reset_n_i(reset_n), .host_i(host), .rdata_o(rdata),
        .mode_i(mode), .conv_i(conv), .ready_pin_o(rdy_pin), .ready_bit_o(rdy_bit),
        .register_error_o(reg_err), .converter_error_o(conv_err),
        .modulator_reset_o(mod_rst), .conversion_hold_o(hold), .io_pin_config_o(cfg),
        .sync_error_pin_i(sync_pin), .sync_error_pin_o(sync_o),
        .sync_error_pin_oe_o(sync_oe), .general_pin_i(gp_pin),
        .general_pin_o(gp_o), .general_pin_oe_o(gp_oe)
    );

    task automatic test_done;
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input int busy);
        acrg_host_model_i.rd(a, busy, d);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] dat);
        acrg_host_model_i.wr(a, dat);
    endtask

    task automatic convert(input logic [23:0] raw);
        @(negedge clk);
        conv.raw = raw;
        conv.conv_done = 1'h1;
        @(negedge clk);
        conv.conv_done = 1'h0;
    endtask

    // whole run is about 130 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        cyc(8);
        reset_n = 1'h1;
        rd(6'h06, 0); chk(d, 32'h00000800);
        rd(6'h03, 0); chk(d, 32'h0);
        rd(6'h04, 0); chk(d, 32'h0);
        rd(6'h05, 0); chk(d, 32'h0);
        tb_sync = 1'h0;
        cyc(3); chk(mod_rst, 32'h1);
        mode.alternate_sync_mode = 1'h1;
        mode.multi_channel = 1'h1;
        cyc(3); chk(mod_rst, 32'h0);
        conv.channel_switch = 1'h1;
        cyc(1);
        conv.channel_switch = 1'h0;
        cyc(2); chk(hold, 32'h1);
        tb_sync = 1'h1;
        cyc(3); chk(hold, 32'h0);
        mode.bipolar_select = 1'h1;
        convert(24'h123456);
        cyc(1); chk({rdy_pin, rdy_bit}, 32'h0);
        rd(6'h04, 0); chk(d, 32'h00923456);
        chk({rdy_pin, rdy_bit}, 32'h3);
        rd(6'h04, 0); chk(d, 32'h00923456);
        fork
            rd(6'h04, 4);
            begin
                cyc(2);
                convert(24'h0f0f0f);
            end
        join
        chk(rdy_pin, 32'h1);
        rd(6'h04, 0); chk(d, 32'h00923456);
        mode.bipolar_select = 1'h0;
        convert(24'h0abcde);
        rd(6'h04, 0); chk(d, 32'h000abcde);
        mode.short_word_select = 1'h1;
        convert(24'h123480);
        rd(6'h04, 0); chk(d, 32'h00001235);
        convert(24'hffffc0);
        rd(6'h04, 0); chk(d, 32'h0000ffff);
        mode.short_word_select = 1'h0;
        mode.status_append = 1'h1;
        conv.status_low = 8'h05;
        convert(24'h00beef);
        rd(6'h04, 0); chk(d, 32'h00beef05);
        mode.status_append = 1'h0;
        conv.checked_xor = 24'h00a5a5;
        mode.check_enable = 1'h1;
        cyc(2);
        rd(6'h03, 0); chk(d, 32'h0000ada5);
        chk(reg_err, 32'h0);
        wr(6'h06, 16'h0801);
        cyc(2); chk(reg_err, 32'h1);
        mode.check_enable = 1'h0;
        cyc(2); chk(reg_err, 32'h0);
        rd(6'h03, 0); chk(d, 32'h0);
        wr(6'h06, 16'hf8c0);
        chk(cfg, 32'h1800);
        rd(6'h06, 0); chk(d, 32'h00001800);
        for (int ch = 0; ch < 4; ch++) begin
            conv.channel = ch[1:0];
            cyc(3); chk({gp_oe, gp_o}, {28'h0, 2'h3, ch[1:0]});
        end
        wr(6'h06, 16'h0200);
        tb_sync = 1'h0;
        cyc(3); chk(conv_err, 32'h1);
        rd(6'h06, 0); chk(d, 32'h00000200);
        tb_sync = 1'h1;
        cyc(3); chk(conv_err, 32'h0);
        rd(6'h06, 0); chk(d, 32'h00000300);
        wr(6'h06, 16'h0400);
        conv.crc_error = 1'h1;
        cyc(3); chk({sync_oe, sync_o}, 32'h2);
        conv.crc_error = 1'h0;
        cyc(3); chk(sync_pin, 32'h1);
        wr(6'h06, 16'h0600);
        cyc(3); chk({sync_oe, sync_o}, 32'h2);
        wr(6'h06, 16'h0700);
        cyc(3); chk({sync_oe, sync_o}, 32'h3);
        wr(6'h06, 16'h0000);
        cyc(3); chk(sync_oe, 32'h0);
        tb_sync = 1'h0;
        cyc(3); chk({conv_err, mod_rst}, 32'h0);
        wr(6'h06, 16'h0030);
        rd(6'h06, 0); chk(d, 32'h00000031);
        // mid-run reset must bring back every reset value
        reset_n = 1'h0;
        cyc(2);
        reset_n = 1'h1;
        chk({rdy_pin, rdy_bit, cfg}, 32'h00030800);
        chk(rdata, 32'h0);
        chk({reg_err, conv_err, mod_rst, hold, sync_oe, gp_oe}, 32'h0);
        test_done();
    end
endmodule // testbench
